// ---- hw/sad_pkg.sv ----
// Shared constants for the secure-alias address decoder: slave map, bus split and access states.
// Assumes a 32-bit byte address space and a single system clock.
package sad_pkg;

	localparam int NUM_SLV = 12;
	localparam int SLV_IDX_W = 4;
	localparam int SEC_BIT = 28;
	localparam int SUB_BITS = 3;
	localparam logic [31:0] SYS_BASE = 32'h2000_0000;
	localparam logic [31:0] FLASH_USE_END = 32'h0003_cfff;
	localparam logic [4:0] RGN_SZ_MIN = 5'h05;
	localparam int CODE_MST = 0;
	localparam int SYS_MST = 1;
	localparam logic [1:0] AP_NONE = 2'h0;
	localparam logic [1:0] AP_RO = 2'h1;
	localparam logic [SLV_IDX_W-1:0] SLV_FLASH = 4'h0;

	// Physical windows with the alias bit cleared: flash, boot ROM, code SRAM, three SRAM banks,
	// USB SRAM, two APB bridges and three AHB peripheral ports.
	localparam logic [31:0] SLV_LO [NUM_SLV] = '{
		32'h0000_0000, 32'h0300_0000, 32'h0400_0000, 32'h2000_0000, 32'h2000_8000, 32'h2000_c000,
		32'h2001_0000, 32'h4000_0000, 32'h4002_0000, 32'h4008_0000, 32'h4009_0000, 32'h400a_0000};
	localparam logic [31:0] SLV_HI [NUM_SLV] = '{
		32'h0003_ffff, 32'h0301_ffff, 32'h0400_3fff, 32'h2000_7fff, 32'h2000_bfff, 32'h2000_ffff,
		32'h2001_3fff, 32'h4001_ffff, 32'h4003_ffff, 32'h4008_ffff, 32'h4009_ffff, 32'h400a_ffff};

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_RESP = 3'b100
	} sad_state_t;

	// Clears the alias bit so both aliases select the same physical location.
	function automatic logic [31:0] sad_phys(input logic [31:0] a);
		logic [31:0] p;
		p = a;
		p[SEC_BIT] = 1'b0;
		return p;
	endfunction

	// Returns {hit, slave index} for a physical address; rsvd trims the reserved flash top.
	function automatic logic [SLV_IDX_W:0] sad_decode(input logic [31:0] p, input logic rsvd);
		logic [SLV_IDX_W:0] r;
		logic [31:0] hi;
		r = '0;
		for (int i = 0; i < NUM_SLV; i++) begin
			hi = (i == int'(SLV_FLASH) && rsvd) ? FLASH_USE_END : SLV_HI[i];
			if (p >= SLV_LO[i] && p <= hi) begin
				r = {1'b1, SLV_IDX_W'(i)};
			end
		end
		return r;
	endfunction

endpackage

// ---- hw/sad_chk_if.sv ----
// Carries one master's pending access to the region checker and its verdict back.
// Assumes the checker answers combinationally in the same cycle.
`timescale 1ns/1ps
interface sad_chk_if;
	logic [31:0] addr;
	logic write;
	logic fetch;
	logic nonsec;
	logic allow;
	logic hit;

	modport req (output addr, output write, output fetch, output nonsec, input allow, input hit);
	modport chk (input addr, input write, input fetch, input nonsec, output allow, output hit);
endinterface

// ---- hw/sad_region_protector.sv ----
// Region protector: eight regions of eight subregions each, with access rights and secure checks.
// Assumes configuration inputs are stable while accesses are checked.
`timescale 1ns/1ps
module sad_region_protector #(
	parameter int NR = 8,
	parameter bit CHECK = 1'b1
) (
	input wire logic sys_clk_i, // System clock, used by checks only.
	input wire logic rst_i, // Synchronous reset, active high.
	sad_chk_if.chk chk, // Access under test and verdict.
	input wire logic rp_en_i, // Protector enable.
	input wire logic [NR-1:0] rgn_en_i, // Region enables.
	input wire logic [NR-1:0][31:0] rgn_base_i, // Region base, aligned to size.
	input wire logic [NR-1:0][4:0] rgn_size_i, // Region size as log2 of bytes.
	input wire logic [NR-1:0][7:0] rgn_srd_i, // Subregion disable bits.
	input wire logic [NR-1:0][1:0] rgn_ap_i, // Access rights: none, read only, read-write.
	input wire logic [NR-1:0] rgn_nsc_i // Region is non-secure callable.
);

	logic hit;
	logic nsc;
	logic [1:0] ap;
	logic perm_ok;
	logic sec_ok;

	////////////////////////////////////////////////////////////////////////////
	// The highest matching region wins, so small regions can carve holes in large ones.
	always_comb begin
		logic [4:0] sz;
		logic [31:0] mask;
		logic [31:0] sub;
		sz = '0;
		mask = '0;
		sub = '0;
		hit = 1'b0;
		nsc = 1'b0;
		ap = sad_pkg::AP_NONE;
		for (int r = 0; r < NR; r++) begin
			sz = (rgn_size_i[r] < sad_pkg::RGN_SZ_MIN) ? sad_pkg::RGN_SZ_MIN : rgn_size_i[r];
			mask = ~((32'h1 << sz) - 32'h1);
			sub = (chk.addr >> (sz - 5'(sad_pkg::SUB_BITS))) & 32'h7; // [RULE11]
			if (rgn_en_i[r] && (chk.addr & mask) == (rgn_base_i[r] & mask) && !rgn_srd_i[r][sub[2:0]]) begin
				hit = 1'b1;
				ap = rgn_ap_i[r];
				nsc = rgn_nsc_i[r];
			end
		end
	end

	// Rights check, then the secure alias may be entered from non-secure code only by fetch from a callable region.
	assign perm_ok = (ap != sad_pkg::AP_NONE) && !(ap == sad_pkg::AP_RO && chk.write); // [RULE12]
	assign sec_ok = !(chk.nonsec && chk.addr[sad_pkg::SEC_BIT]) || (hit && nsc && chk.fetch); // [RULE10]
	assign chk.allow = !CHECK || ((!rp_en_i || (hit && perm_ok)) && sec_ok); // [RULE13]
	assign chk.hit = hit;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the verdict.
	if (CHECK) begin : g_ast
		AST_NO_REGION_DENY: // [RULE13]
		assert property (@(posedge sys_clk_i) disable iff (rst_i) (rp_en_i && !hit) |-> !chk.allow)
			else $error("Access outside every region was allowed.");
		AST_RO_WRITE: // [RULE12]
		assert property (@(posedge sys_clk_i) disable iff (rst_i)
			(rp_en_i && hit && ap == sad_pkg::AP_RO && chk.write) |-> !chk.allow)
			else $error("Write to a read-only region was allowed.");
		AST_NSC_ONLY_FETCH: // [RULE10]
		assert property (@(posedge sys_clk_i) disable iff (rst_i)
			(chk.nonsec && chk.addr[sad_pkg::SEC_BIT] && !chk.fetch) |-> !chk.allow)
			else $error("Non-secure data access reached the secure alias.");
	end

endmodule // sad_region_protector

// ---- hw/sad_decoder_top.sv ----
// Address decoder and slave-port matrix behind the code bus, the system bus and further masters.
// Assumes masters hold a request until answered and slaves answer while selected.
// Function
// [RULE1] Code bus carries every access to 0x00000000 through 0x1FFFFFFF.
// [RULE2] System bus carries every access from 0x20000000 through 0xFFFFFFFF.
// [RULE3] Masters reach different slave ports together; only one slave port's contenders serialise.
// [RULE4] Address bit 28 marks secure alias when set, non-secure when clear.
// [RULE5] Slave selection ignores bit 28; separate checking decides permitted access kinds.
// [RULE6] Code range 0x0000_0000-0x0FFF_FFFF maps flash, boot ROM, code SRAM; bit 28 secure.
// [RULE7] Data range 0x2000_0000-0x2FFF_FFFF maps three SRAM banks and USB SRAM.
// [RULE8] Range 0x4000_0000-0x4FFF_FFFF maps peripherals; secure alias from 0x5000_0000.
// [RULE9] Masters form secure peripheral addresses by setting bit 28 of the base.
// [RULE10] Secure parts may be non-secure callable; only configured access kinds pass.
// [RULE11] Protector supports eight regions, each split into eight subregions.
// [RULE12] Regions may deny all or allow reads only; read-only writes are blocked.
// [RULE13] Access in no region, or forbidden by it, raises a management fault.
// [RULE14] Top 12 KB of the 256 KB flash is reserved, leaving 244 KB.
// [RULE15] SRAM bank 0 sits at 0x2000_0000-0x2000_7FFF, secure alias 0x3000_0000.
// [RULE16] 0x4000_0000-0x4001_FFFF and secure 0x5000_0000 onward reach the first bridge.
// [RULE17] Unoccupied addresses inside a bus region end with an error response.
`timescale 1ns/1ps
module sad_decoder_top #(
	parameter int NM = 3, // Masters: 0 code bus, 1 system bus, others anywhere.
	parameter int NR = 8, // Protector regions.
	parameter bit FLASH_RSVD = 1'b1 // Largest flash option with reserved top pages.
) (
	input wire logic sys_clk_i, // System clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic [NM-1:0] mst_req_i, // Request held until answered.
	input wire logic [NM-1:0][31:0] mst_addr_i, // Request address.
	input wire logic [NM-1:0] mst_write_i, // Write when high.
	input wire logic [NM-1:0] mst_fetch_i, // Instruction fetch when high.
	input wire logic [NM-1:0] mst_nonsec_i, // Request issued from non-secure state.
	input wire logic [NM-1:0][31:0] mst_wdata_i, // Write data.
	output logic [NM-1:0] mst_ready_o, // One-cycle answer strobe.
	output logic [NM-1:0][31:0] mst_rdata_o, // Read data, registered.
	output logic [NM-1:0] mst_err_o, // Error answer, registered.
	output logic [NM-1:0] mst_fault_o, // Management fault with the answer, registered.
	output logic [NM-1:0] mst_secure_o, // Access went to the secure alias, registered.
	output logic [sad_pkg::NUM_SLV-1:0] slv_sel_o, // Slave select, held until slave ready.
	output logic [sad_pkg::NUM_SLV-1:0][31:0] slv_addr_o, // Physical address with bit 28 clear.
	output logic [sad_pkg::NUM_SLV-1:0] slv_write_o, // Slave write.
	output logic [sad_pkg::NUM_SLV-1:0][31:0] slv_wdata_o, // Slave write data.
	input wire logic [sad_pkg::NUM_SLV-1:0] slv_ready_i, // Slave done.
	input wire logic [sad_pkg::NUM_SLV-1:0][31:0] slv_rdata_i, // Slave read data.
	input wire logic [sad_pkg::NUM_SLV-1:0] slv_err_i, // Slave error.
	input wire logic rp_en_i, // Protector enable.
	input wire logic [NR-1:0] rgn_en_i, // Region enables.
	input wire logic [NR-1:0][31:0] rgn_base_i, // Region bases.
	input wire logic [NR-1:0][4:0] rgn_size_i, // Region sizes, log2 bytes.
	input wire logic [NR-1:0][7:0] rgn_srd_i, // Subregion disables.
	input wire logic [NR-1:0][1:0] rgn_ap_i, // Region access rights.
	input wire logic [NR-1:0] rgn_nsc_i // Non-secure callable marks.
);

	localparam int SW = sad_pkg::SLV_IDX_W;

	sad_pkg::sad_state_t st [NM];
	sad_pkg::sad_state_t next_st [NM];
	logic [SW-1:0] tgt [NM];
	logic [SW-1:0] next_tgt [NM];
	logic [31:0] adr [NM];
	logic [31:0] next_adr [NM];
	logic wr [NM];
	logic next_wr [NM];
	logic [31:0] wd [NM];
	logic [31:0] next_wd [NM];
	logic [31:0] rdat [NM];
	logic [31:0] next_rdat [NM];
	logic err [NM];
	logic next_err [NM];
	logic flt [NM];
	logic next_flt [NM];
	logic sec [NM];
	logic next_sec [NM];
	logic [NM-1:0] req_bad;
	logic [NM-1:0] req_flt;
	logic [SW-1:0] req_tgt [NM];
	logic [NM-1:0] gnt;

	sad_chk_if chk_if [NM] ();

	////////////////////////////////////////////////////////////////////////////
	// Per-master decode, protection check and access sequence.
	for (genvar m = 0; m < NM; m++) begin : g_mst
		logic [SW:0] dec;
		logic bus_ok;

		// Only the two processor buses pass through the protector.
		sad_region_protector #(.NR(NR), .CHECK(m <= sad_pkg::SYS_MST)) u_prot (
			.sys_clk_i(sys_clk_i),
			.rst_i(rst_i),
			.chk(chk_if[m]),
			.rp_en_i(rp_en_i),
			.rgn_en_i(rgn_en_i),
			.rgn_base_i(rgn_base_i),
			.rgn_size_i(rgn_size_i),
			.rgn_srd_i(rgn_srd_i),
			.rgn_ap_i(rgn_ap_i),
			.rgn_nsc_i(rgn_nsc_i)
		);
		assign chk_if[m].addr = mst_addr_i[m];
		assign chk_if[m].write = mst_write_i[m];
		assign chk_if[m].fetch = mst_fetch_i[m];
		assign chk_if[m].nonsec = mst_nonsec_i[m]; // [RULE9]

		// Both aliases decode to one slave; the map holds flash, SRAMs and bridges. [RULE5] [RULE6] [RULE7]
		assign dec = sad_pkg::sad_decode(sad_pkg::sad_phys(mst_addr_i[m]), FLASH_RSVD); // [RULE8] [RULE15] [RULE16] [RULE14]
		// The code bus owns everything below the system base, the system bus the rest.
		assign bus_ok = (m == sad_pkg::CODE_MST) ? (mst_addr_i[m] < sad_pkg::SYS_BASE) : // [RULE1]
			(m == sad_pkg::SYS_MST) ? (mst_addr_i[m] >= sad_pkg::SYS_BASE) : 1'b1; // [RULE2]
		assign req_flt[m] = bus_ok && dec[SW] && !chk_if[m].allow; // [RULE13]
		assign req_bad[m] = !bus_ok || !dec[SW] || !chk_if[m].allow; // [RULE17]
		assign req_tgt[m] = dec[SW-1:0];

		// Next state: refused requests answer at once with an error, granted ones wait on the slave.
		always_comb begin
			next_st[m] = st[m];
			next_tgt[m] = tgt[m];
			next_adr[m] = adr[m];
			next_wr[m] = wr[m];
			next_wd[m] = wd[m];
			next_rdat[m] = rdat[m];
			next_err[m] = err[m];
			next_flt[m] = 1'b0;
			next_sec[m] = sec[m];
			case (st[m])
				sad_pkg::ST_IDLE: begin
					if (mst_req_i[m] && req_bad[m]) begin
						next_st[m] = sad_pkg::ST_RESP;
						next_err[m] = 1'b1;
						next_flt[m] = req_flt[m];
						next_rdat[m] = '0;
						next_sec[m] = mst_addr_i[m][sad_pkg::SEC_BIT];
					end else if (gnt[m]) begin
						next_st[m] = sad_pkg::ST_BUSY;
						next_tgt[m] = req_tgt[m];
						next_adr[m] = mst_addr_i[m];
						next_wr[m] = mst_write_i[m];
						next_wd[m] = mst_wdata_i[m];
						next_sec[m] = mst_addr_i[m][sad_pkg::SEC_BIT]; // [RULE4]
					end
				end
				sad_pkg::ST_BUSY: begin
					if (slv_ready_i[tgt[m]]) begin
						next_st[m] = sad_pkg::ST_RESP;
						next_rdat[m] = slv_rdata_i[tgt[m]];
						next_err[m] = slv_err_i[tgt[m]];
					end
				end
				sad_pkg::ST_RESP: begin
					next_st[m] = sad_pkg::ST_IDLE;
					next_err[m] = 1'b0;
				end
				default: begin
					next_st[m] = sad_pkg::ST_IDLE;
				end
			endcase
		end

		// Registers only.
		always_ff @(posedge sys_clk_i) begin
			if (rst_i) begin
				st[m] <= sad_pkg::ST_IDLE;
				tgt[m] <= '0;
				adr[m] <= '0;
				wr[m] <= 1'b0;
				wd[m] <= '0;
				rdat[m] <= '0;
				err[m] <= 1'b0;
				flt[m] <= 1'b0;
				sec[m] <= 1'b0;
			end else begin
				st[m] <= next_st[m];
				tgt[m] <= next_tgt[m];
				adr[m] <= next_adr[m];
				wr[m] <= next_wr[m];
				wd[m] <= next_wd[m];
				rdat[m] <= next_rdat[m];
				err[m] <= next_err[m];
				flt[m] <= next_flt[m];
				sec[m] <= next_sec[m];
			end
		end

		// Answer strobe comes straight from the state flop.
		assign mst_ready_o[m] = (st[m] == sad_pkg::ST_RESP);
		assign mst_rdata_o[m] = rdat[m];
		assign mst_err_o[m] = err[m];
		assign mst_fault_o[m] = flt[m];
		assign mst_secure_o[m] = sec[m];

		if (m == sad_pkg::CODE_MST) begin : g_ast_code
			AST_CODE_BUS_ONLY: // [RULE1]
			assert property (@(posedge sys_clk_i) disable iff (rst_i)
				(st[m] == sad_pkg::ST_IDLE && mst_req_i[m] && mst_addr_i[m] >= sad_pkg::SYS_BASE)
				|=> (mst_ready_o[m] && mst_err_o[m] && !mst_fault_o[m]))
				else $error("Code bus accepted a system-range address.");
		end
		if (m == sad_pkg::SYS_MST) begin : g_ast_sys
			AST_SYS_BUS_ONLY: // [RULE2]
			assert property (@(posedge sys_clk_i) disable iff (rst_i)
				(st[m] == sad_pkg::ST_IDLE && mst_req_i[m] && mst_addr_i[m] < sad_pkg::SYS_BASE)
				|=> (mst_ready_o[m] && mst_err_o[m]))
				else $error("System bus accepted a code-range address.");
		end
		AST_UNMAPPED_ERR: // [RULE17]
		assert property (@(posedge sys_clk_i) disable iff (rst_i)
			(st[m] == sad_pkg::ST_IDLE && mst_req_i[m] && !dec[SW]) |=> (mst_ready_o[m] && mst_err_o[m]))
			else $error("Unmapped address did not end in an error.");
		AST_FLASH_RSVD: // [RULE14]
		assert property (@(posedge sys_clk_i) disable iff (rst_i)
			(FLASH_RSVD && st[m] == sad_pkg::ST_IDLE && mst_req_i[m]
			&& sad_pkg::sad_phys(mst_addr_i[m]) > sad_pkg::FLASH_USE_END
			&& sad_pkg::sad_phys(mst_addr_i[m]) <= sad_pkg::SLV_HI[0]) |=> mst_err_o[m])
			else $error("Reserved flash pages were reachable.");
		AST_SECURE_FLAG: // [RULE4]
		assert property (@(posedge sys_clk_i) disable iff (rst_i)
			(st[m] == sad_pkg::ST_BUSY) |-> ##1 (mst_secure_o[m] == adr[m][sad_pkg::SEC_BIT]))
			else $error("Secure flag does not follow address bit 28.");
		AST_FAULT_WITH_ERR: // [RULE13]
		assert property (@(posedge sys_clk_i) disable iff (rst_i)
			mst_fault_o[m] |-> (mst_ready_o[m] && mst_err_o[m] && $past(st[m]) == sad_pkg::ST_IDLE))
			else $error("Fault raised without an immediate error answer.");
	end

	////////////////////////////////////////////////////////////////////////////
	// Arbitration: each free slave port goes to its lowest-numbered contender, so
	// masters on different ports proceed in parallel. Fixed priority can starve high indices.
	always_comb begin
		logic taken;
		taken = 1'b0;
		gnt = '0;
		for (int s = 0; s < sad_pkg::NUM_SLV; s++) begin
			taken = 1'b0;
			for (int m = 0; m < NM; m++) begin
				if (st[m] == sad_pkg::ST_BUSY && tgt[m] == SW'(s)) begin
					taken = 1'b1;
				end
			end
			for (int m = 0; m < NM; m++) begin
				if (!taken && st[m] == sad_pkg::ST_IDLE && mst_req_i[m] && !req_bad[m]
					&& req_tgt[m] == SW'(s)) begin
					gnt[m] = 1'b1; // [RULE3]
					taken = 1'b1;
				end
			end
		end
	end

	// Slave ports are driven from the latched request of their current owner.
	always_comb begin
		slv_sel_o = '0;
		slv_addr_o = '0;
		slv_write_o = '0;
		slv_wdata_o = '0;
		for (int s = 0; s < sad_pkg::NUM_SLV; s++) begin
			for (int m = 0; m < NM; m++) begin
				if (st[m] == sad_pkg::ST_BUSY && tgt[m] == SW'(s)) begin
					slv_sel_o[s] = 1'b1;
					slv_addr_o[s] = sad_pkg::sad_phys(adr[m]); // [RULE5]
					slv_write_o[s] = wr[m];
					slv_wdata_o[s] = wd[m];
				end
			end
		end
	end

	// The system bus and the last master share slave ports, as do the code bus and the last master; only the first pair is checked.
	if (NM > sad_pkg::SYS_MST + 1) begin : g_ast_own
		AST_ONE_OWNER: // [RULE3]
		assert property (@(posedge sys_clk_i) disable iff (rst_i)
			(st[sad_pkg::SYS_MST] == sad_pkg::ST_BUSY && st[NM-1] == sad_pkg::ST_BUSY)
			|-> (tgt[sad_pkg::SYS_MST] != tgt[NM-1]))
			else $error("Two masters own one slave port.");
	end
	AST_ALIAS_CLEAR: // [RULE5]
	assert property (@(posedge sys_clk_i) disable iff (rst_i)
		slv_sel_o[sad_pkg::NUM_SLV-1] |-> !slv_addr_o[sad_pkg::NUM_SLV-1][sad_pkg::SEC_BIT])
		else $error("Alias bit reached a slave.");

endmodule // sad_decoder_top

// ---- dv/sad_slv_model.sv ----
// Behavioural slaves on the twelve decoder ports, sixteen words each.
// Assumes each select stays high until ready is seen, then drops.
`timescale 1ns/1ps
module sad_slv_model (
	input wire logic sys_clk_i, // System clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic [sad_pkg::NUM_SLV-1:0] sel_i, // Slave selects.
	input wire logic [sad_pkg::NUM_SLV-1:0][31:0] addr_i, // Physical addresses.
	input wire logic [sad_pkg::NUM_SLV-1:0] write_i, // Write strobes.
	input wire logic [sad_pkg::NUM_SLV-1:0][31:0] wdata_i, // Write data.
	output logic [sad_pkg::NUM_SLV-1:0] ready_o, // Transfer done.
	output logic [sad_pkg::NUM_SLV-1:0][31:0] rdata_o, // Read data.
	output logic [sad_pkg::NUM_SLV-1:0] err_o // Error for word offset 0xffc or a set alias bit.
);
	logic [31:0] mem [sad_pkg::NUM_SLV][16];
	logic [1:0] cnt [sad_pkg::NUM_SLV];
	////////////////////////////////////////
	// Latency is the port index mod 3, so some ports answer at once and some stall.
	// Outside ready the data lines show the inverse, so stale data never looks right.
	always_comb begin
		for (int s = 0; s < sad_pkg::NUM_SLV; s++) begin
			ready_o[s] = sel_i[s] && (cnt[s] == 2'(s % 3));
			rdata_o[s] = ready_o[s] ? mem[s][addr_i[s][5:2]] : ~mem[s][addr_i[s][5:2]];
			err_o[s] = ready_o[s] && (addr_i[s][11:0] == 12'hffc || addr_i[s][sad_pkg::SEC_BIT]);
		end
	end
	// Counts select cycles and stores write data as the transfer completes.
	always_ff @(posedge sys_clk_i) begin
		for (int s = 0; s < sad_pkg::NUM_SLV; s++) begin
			if (rst_i || !sel_i[s] || ready_o[s]) begin
				cnt[s] <= 2'h0;
			end else begin
				cnt[s] <= cnt[s] + 2'h1;
			end
			if (!rst_i && ready_o[s] && write_i[s]) begin
				mem[s][addr_i[s][5:2]] <= wdata_i[s];
			end
		end
	end
endmodule // sad_slv_model

// ---- dv/sad_decoder_top_tb_top.sv ----
// Self-checking bench for the decoder: map, aliases, bus split, matrix sharing and protection.
// Assumes the slave model above on the far side and three masters driven here.
`timescale 1ns/1ps
module sad_decoder_top_tb_top;
	localparam int NM = 3;
	localparam int NR = 8;
	logic sys_clk_i, rst_i, rp_en, last_sec;
	logic [NM-1:0] req, wr, fe, ns, rdy, err, flt, sec;
	logic [NM-1:0][31:0] addr, wd, rd;
	logic [sad_pkg::NUM_SLV-1:0] s_sel, s_wr, s_rdy, s_err, seen_sel;
	logic [sad_pkg::NUM_SLV-1:0][31:0] s_addr, s_wd, s_rd;
	logic [NR-1:0] r_en, r_nsc;
	logic [NR-1:0][31:0] r_base;
	logic [NR-1:0][4:0] r_size;
	logic [NR-1:0][7:0] r_srd;
	logic [NR-1:0][1:0] r_ap;
	int num_errors, total_checks, peak;
	time t_done [NM];
	////////////////////////////////////////
	sad_decoder_top #(.NM(NM), .NR(NR), .FLASH_RSVD(1'b1)) i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.mst_req_i(req), .mst_addr_i(addr), .mst_write_i(wr), .mst_fetch_i(fe), .mst_nonsec_i(ns),
		.mst_wdata_i(wd), .mst_ready_o(rdy), .mst_rdata_o(rd), .mst_err_o(err), .mst_fault_o(flt),
		.mst_secure_o(sec), .slv_sel_o(s_sel), .slv_addr_o(s_addr), .slv_write_o(s_wr), .slv_wdata_o(s_wd),
		.slv_ready_i(s_rdy), .slv_rdata_i(s_rd), .slv_err_i(s_err), .rp_en_i(rp_en), .rgn_en_i(r_en),
		.rgn_base_i(r_base), .rgn_size_i(r_size), .rgn_srd_i(r_srd), .rgn_ap_i(r_ap), .rgn_nsc_i(r_nsc));
	sad_slv_model i_slv (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sel_i(s_sel), .addr_i(s_addr),
		.write_i(s_wr), .wdata_i(s_wd), .ready_o(s_rdy), .rdata_o(s_rd), .err_o(s_err));
	////////////////////////////////////////
	// Records which slave ports were selected and how many were selected at once.
	always @(posedge sys_clk_i) begin
		seen_sel <= seen_sel | s_sel;
		if ($countones(s_sel) > peak) begin
			peak <= $countones(s_sel);
		end
	end
	// Compares one value and counts the result.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic print_verdict();
		if (num_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// One access: k is {write, fetch, nonsec}; e returns {err, fault}. Request held until ready.
	task automatic acc(input int m, input logic [31:0] a, input logic [2:0] k, input logic [31:0] d,
		output logic [31:0] r, output logic [31:0] e);
		int n;
		@(posedge sys_clk_i);
		#1;
		req[m] = 1'b1;
		addr[m] = a;
		{wr[m], fe[m], ns[m]} = k;
		wd[m] = d;
		seen_sel = '0;
		for (n = 0; n < 50 && rdy[m] !== 1'b1; n++) begin
			@(posedge sys_clk_i);
			#1;
		end
		if (rdy[m] !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %0t no answer to master %0d", $time, m);
			print_verdict();
		end else begin
			r = rd[m];
			e = {30'h0, err[m], flt[m]};
			last_sec = sec[m];
			t_done[m] = $time;
			req[m] = 1'b0;
		end
	endtask
	////////////////////////////////////////
	// Writes each slave port through its plain address and reads it back through the alias.
	task automatic t_map();
		logic [31:0] r, e, a;
		int m;
		for (int i = 0; i < sad_pkg::NUM_SLV; i++) begin
			a = sad_pkg::SLV_LO[i] + 32'h4;
			m = (a < 32'h2000_0000) ? 0 : 1;
			acc(m, a, 3'h5, a ^ 32'h5a5a_0000, r, e);
			check(e, 32'h0);
			check(32'(seen_sel), 32'h1 << i);
			check({31'h0, last_sec}, 32'h0);
			acc(m, a | 32'h1000_0000, 3'h0, 32'h0, r, e);
			check(e, 32'h0);
			check(r, a ^ 32'h5a5a_0000);
			check({31'h0, last_sec}, 32'h1);
		end
	endtask
	// Bus split, reserved flash top, holes, bank and bridge edges, and a slave error.
	task automatic t_table();
		logic [31:0] r, e;
		int tm [11] = '{0, 1, 0, 1, 0, 0, 1, 1, 1, 2, 2};
		logic [31:0] ta [11] = '{32'h2000_0000, 32'h0000_0000, 32'h1fff_fffc, 32'hffff_fffc, 32'h0003_cff8,
			32'h0003_d000, 32'h2002_0000, 32'h2000_7ff8, 32'h4001_fff8, 32'h5001_0000, 32'h3000_0ffc};
		logic [31:0] te [11] = '{32'h2, 32'h2, 32'h2, 32'h2, 32'h0, 32'h2, 32'h2, 32'h0, 32'h0, 32'h0, 32'h2};
		logic [11:0] ts [11] = '{12'h0, 12'h0, 12'h0, 12'h0, 12'h1, 12'h0, 12'h0, 12'h8, 12'h80, 12'h80, 12'h8};
		for (int i = 0; i < 11; i++) begin
			acc(tm[i], ta[i], 3'h0, 32'h0, r, e);
			check(e, te[i]);
			check(32'(seen_sel), 32'(ts[i]));
		end
	endtask
	// Two masters on different ports overlap; on one port the lower index goes first.
	task automatic t_conc();
		logic [31:0] r1, e1, r2, e2;
		peak = 0;
		fork
			acc(1, 32'h2000_c000, 3'h0, 32'h0, r1, e1);
			acc(2, 32'h2000_8000, 3'h0, 32'h0, r2, e2);
		join
		check(32'(peak), 32'h2);
		peak = 0;
		fork
			acc(1, 32'h2000_c000, 3'h0, 32'h0, r1, e1);
			acc(2, 32'h2000_c000, 3'h0, 32'h0, r2, e2);
		join
		check(32'(peak), 32'h1);
		check({31'h0, t_done[1] < t_done[2]}, 32'h1);
	endtask
	// Read-only region 0 under region 7 with seven subregions disabled, then no access at all.
	task automatic t_prot();
		logic [31:0] r, e;
		int tm [6] = '{1, 1, 1, 1, 2, 1};
		logic [31:0] ta [6] = '{32'h2000_0010, 32'h2000_1010, 32'h2000_1010, 32'h2000_8000, 32'h2000_1010,
			32'h2000_1010};
		logic [2:0] tk [6] = '{3'h4, 3'h4, 3'h0, 3'h0, 3'h4, 3'h0};
		logic [31:0] te [6] = '{32'h0, 32'h3, 32'h0, 32'h3, 32'h0, 32'h3};
		rp_en = 1'b1;
		r_en = 8'h81;
		r_base[0] = 32'h2000_0000;
		r_size[0] = 5'h0f;
		r_ap[0] = sad_pkg::AP_RO;
		r_base[7] = 32'h2000_0000;
		r_size[7] = 5'h0f;
		r_ap[7] = 2'h3;
		r_srd[7] = 8'hfe;
		for (int i = 0; i < 6; i++) begin
			if (i == 5) begin
				r_ap[0] = sad_pkg::AP_NONE;
			end
			acc(tm[i], ta[i], tk[i], 32'h0, r, e);
			check(e, te[i]);
		end
		rp_en = 1'b0;
		r_en = 8'h00;
	endtask
	// Non-secure entry to the secure alias: fetches of callable areas only.
	task automatic t_nsc();
		logic [31:0] r, e;
		logic [2:0] tk [4] = '{3'h3, 3'h1, 3'h3, 3'h0};
		logic [31:0] te [4] = '{32'h0, 32'h3, 32'h3, 32'h0};
		r_en = 8'h0c;
		r_base[2] = 32'h0000_0000;
		r_base[3] = 32'h1000_0000;
		r_size[2] = 5'h12;
		r_size[3] = 5'h12;
		r_ap[2] = 2'h3;
		r_ap[3] = 2'h3;
		r_nsc = 8'h0c;
		for (int i = 0; i < 4; i++) begin
			if (i == 2) begin
				r_nsc = 8'h00;
			end
			acc(0, 32'h1000_0010, tk[i], 32'h0, r, e);
			check(e, te[i]);
		end
	endtask
	////////////////////////////////////////
	// Free-running 100 MHz clock.
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// Reset for five cycles, then the scenarios in turn.
	initial begin
		rst_i = 1'b1;
		{req, wr, fe, ns, addr, wd} = '0;
		{rp_en, r_en, r_nsc, r_base, r_size, r_srd, r_ap} = '0;
		{seen_sel, peak, num_errors, total_checks} = '0;
		repeat (5) @(posedge sys_clk_i);
		#1;
		rst_i = 1'b0;
		t_map();
		t_table();
		t_conc();
		t_prot();
		t_nsc();
		print_verdict();
	end
endmodule // sad_decoder_top_tb_top
